// ---- hdl/lsc_pkg.sv ----
// Constants, types and helpers shared by the serial LED command block
package lsc_pkg;

  localparam logic [1:0] LSC_OP_MODE   = 2'h1;
  localparam logic [1:0] LSC_OP_CTRL   = 2'h2;
  localparam logic [1:0] LSC_OP_ADDR   = 2'h3;
  localparam int         LSC_OP_MSB    = 7;
  localparam int         LSC_OP_LSB    = 6;
  localparam int         LSC_ON_BIT    = 3;
  localparam int         LSC_RD_BIT    = 1;
  localparam int         LSC_FIX_BIT   = 2;
  localparam logic [7:0] LSC_KEY_READ  = 8'h42;
  localparam logic [7:0] LSC_KEY_NONE  = 8'hFF;
  localparam logic [1:0] LSC_ADDR_RST  = 2'h0;
  localparam logic [1:0] LSC_ADDR_LAST = 2'h3;
  localparam logic [3:0] LSC_BYTE_BITS = 4'h8;
  localparam int         LSC_DIGITS    = 4;
  localparam int         LSC_SEGS      = 7;
  localparam int         LSC_KEYS      = 7;
  localparam int         LSC_MCLK_HZ   = 125_000_000;
  localparam int         LSC_OSC_HZ    = 500_000;
  localparam int         LSC_OSC_DIV   = LSC_MCLK_HZ / LSC_OSC_HZ;

  localparam logic [7:0] LSC_KEY_CODE [LSC_KEYS] = '{8'hEF, 8'h6F, 8'hAF, 8'h2F, 8'hCF, 8'h4F, 8'h8F};

  typedef struct packed {
    logic       on;
    logic [2:0] level;
  } lsc_disp_t;

  localparam lsc_disp_t LSC_DISP_RST = '{on: 1'b0, level: 3'h0};

  typedef enum logic [1:0] {
    LSC_IDLE = 2'b00,
    LSC_RX   = 2'b01,
    LSC_TX   = 2'b10
  } lsc_state_t;

  // Lit sixteenths of a digit slot for each brightness level
  function automatic logic [4:0] lsc_width(input logic [2:0] lvl);
    logic [4:0] w;
    w = 5'h01;
    case (lvl)
      3'h0: w = 5'h01;
      3'h1: w = 5'h02;
      3'h2: w = 5'h04;
      3'h3: w = 5'h0A;
      3'h4: w = 5'h0B;
      3'h5: w = 5'h0C;
      3'h6: w = 5'h0D;
      default: w = 5'h0E;
    endcase
    return w;
  endfunction

endpackage

// ---- hdl/lsc_serial_ctrl.sv ----
// Two-wire command interpreter, display memory and digit multiplexer
// Functional notes
// - Command with top bits 10 is display control: switch plus eight brightness levels.
// - Low three control bits pick lit width 1,2,4,10,11,12,13,14 sixteenths.
// - Control bit three off blanks digit and segment outputs; on drives stored pattern.
// - Auto mode: mode 0x40, address, up to four bytes stored, address advancing.
// - Address command loads pointer 0xC0 to 0xC3 from its low two bits.
// - Mode 0x44 keeps the pointer unchanged after each stored byte.
// - Every received command or data byte is acknowledged.
// - After key read command 0x42 the device shifts out one key code byte.
// - Only one pressed key is reported; the lowest input wins.
// - Data falling with clock high starts; rising with clock high stops.
// - Acknowledge drives line low from eighth fall until ninth rise.
// - First byte is a command decoded by its top two bits.
// - Key codes 0xEF,0x6F,0xAF,0x2F,0xCF,0x4F,0x8F; 0xFF when none.
`timescale 1ns/1ps
`default_nettype none

module lsc_serial_ctrl
  import lsc_pkg::*;
#(
  parameter int OSC_DIV = LSC_OSC_DIV
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  serial_clk_i,
  input  wire logic                  bidir_serial_line_i,
  output logic                       bidir_serial_line_o,
  output logic                       bidir_serial_line_oe_o,
  input  wire logic [LSC_KEYS-1:0]   key_sense_inputs_i,
  output logic      [LSC_SEGS-1:0]   segment_output_o,
  output logic      [LSC_DIGITS-1:0] digit_output_o,
  output lsc_disp_t                  display_cfg_o
);

  // Link domain: bit captured on the serial clock rising edge. It holds until
  // the next rise, at least a clock pulse later, so the main domain reads it
  // qualified by its own synchronised copy of that edge.
  logic bit_l;

  always_ff @(posedge serial_clk_i) begin
    bit_l <= bidir_serial_line_i;
  end

  logic       clk_s1_q, clk_s2_q, clk_s3_q;
  logic       dat_s1_q, dat_s2_q, dat_s3_q;
  logic [LSC_KEYS-1:0] key_s1_q, key_s2_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      clk_s1_q <= 1'b1;
      clk_s2_q <= 1'b1;
      clk_s3_q <= 1'b1;
      dat_s1_q <= 1'b1;
      dat_s2_q <= 1'b1;
      dat_s3_q <= 1'b1;
      key_s1_q <= '0;
      key_s2_q <= '0;
    end else begin
      clk_s1_q <= serial_clk_i;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= bidir_serial_line_i;
      dat_s2_q <= dat_s1_q;
      dat_s3_q <= dat_s2_q;
      key_s1_q <= key_sense_inputs_i;
      key_s2_q <= key_s1_q;
    end
  end

  lsc_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic       first_q;
  logic       ack_q;
  logic       guard_q;
  lsc_disp_t  disp_q;
  logic [1:0] addr_q;
  logic       fixed_q;
  logic       ovf_q;
  logic [LSC_SEGS-1:0] ram_q [LSC_DIGITS];

  logic       rise, fall, start, stop, byte_end, is_ctrl, is_addr, key_cmd;
  logic [7:0] key_code;

  assign rise  = clk_s2_q & ~clk_s3_q;
  assign fall  = ~clk_s2_q & clk_s3_q;
  // Own drive and the release right after an acknowledge must not look like a frame edge
  assign start = clk_s2_q & clk_s3_q & dat_s3_q & ~dat_s2_q & ~bidir_serial_line_oe_o;
  assign stop  = clk_s2_q & clk_s3_q & ~dat_s3_q & dat_s2_q & ~guard_q;
  assign byte_end = fall & (st_q == LSC_RX) & (cnt_q == LSC_BYTE_BITS) & ~ack_q;
  assign is_ctrl  = first_q & (rx_q[LSC_OP_MSB:LSC_OP_LSB] == LSC_OP_CTRL);
  assign is_addr  = first_q & (rx_q[LSC_OP_MSB:LSC_OP_LSB] == LSC_OP_ADDR);
  assign key_cmd  = first_q & (rx_q[LSC_OP_MSB:LSC_OP_LSB] == LSC_OP_MODE) & rx_q[LSC_RD_BIT];

  // Lowest pressed input wins; combined presses give no merged code
  always_comb begin
    key_code = LSC_KEY_NONE;
    for (int k = LSC_KEYS - 1; k >= 0; k--) begin
      if (key_s2_q[k]) begin
        key_code = LSC_KEY_CODE[k];
      end
    end
  end

  // Serial framing, acknowledge and key code shifting; bytes go LSB first
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q                   <= LSC_IDLE;
      cnt_q                  <= '0;
      rx_q                   <= '0;
      tx_q                   <= '0;
      first_q                <= 1'b0;
      ack_q                  <= 1'b0;
      guard_q                <= 1'b0;
      bidir_serial_line_o    <= 1'b1;
      bidir_serial_line_oe_o <= 1'b0;
    end else if (stop) begin
      st_q                   <= LSC_IDLE;
      ack_q                  <= 1'b0;
      bidir_serial_line_oe_o <= 1'b0;
    end else if (start) begin
      st_q    <= LSC_RX;
      cnt_q   <= '0;
      first_q <= 1'b1;
      ack_q   <= 1'b0;
    end else begin
      if (fall) begin
        guard_q <= 1'b0;
      end
      unique case (st_q)
        LSC_IDLE: begin
        end
        LSC_RX: begin
          if (rise && !ack_q && cnt_q != LSC_BYTE_BITS) begin
            rx_q  <= {bit_l, rx_q[7:1]};
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_end) begin
            ack_q                  <= 1'b1;
            bidir_serial_line_o    <= 1'b0;
            bidir_serial_line_oe_o <= 1'b1;
          end
          if (rise && ack_q) begin
            ack_q                  <= 1'b0;
            bidir_serial_line_oe_o <= 1'b0;
            bidir_serial_line_o    <= 1'b1;
            guard_q                <= 1'b1;
            cnt_q                  <= '0;
            first_q                <= 1'b0;
            if (key_cmd) begin
              st_q <= LSC_TX;
              tx_q <= key_code;
            end
          end
        end
        LSC_TX: begin
          if (fall && cnt_q != LSC_BYTE_BITS) begin
            bidir_serial_line_oe_o <= 1'b1;
            bidir_serial_line_o    <= tx_q[0];
            tx_q                   <= {1'b1, tx_q[7:1]};
            cnt_q                  <= cnt_q + 4'h1;
          end else if (fall) begin
            bidir_serial_line_oe_o <= 1'b0;
            bidir_serial_line_o    <= 1'b1;
            st_q                   <= LSC_IDLE;
          end
        end
        default: begin
          st_q <= LSC_IDLE;
        end
      endcase
    end
  end

  // Command registers and address pointer
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      disp_q  <= LSC_DISP_RST;
      addr_q  <= LSC_ADDR_RST;
      fixed_q <= 1'b0;
      ovf_q   <= 1'b0;
    end else if (byte_end) begin
      if (first_q) begin
        unique case (rx_q[LSC_OP_MSB:LSC_OP_LSB])
          LSC_OP_MODE: fixed_q <= rx_q[LSC_FIX_BIT];
          LSC_OP_CTRL: begin
            disp_q.on    <= rx_q[LSC_ON_BIT];
            disp_q.level <= rx_q[2:0];
          end
          LSC_OP_ADDR: begin
            addr_q <= rx_q[1:0];
            ovf_q  <= 1'b0;
          end
          default: begin
          end
        endcase
      end else if (!ovf_q && !fixed_q) begin
        if (addr_q == LSC_ADDR_LAST) begin
          ovf_q <= 1'b1;
        end else begin
          addr_q <= addr_q + 2'h1;
        end
      end
    end
  end

  // Display memory; bit 7 of a data byte has no segment
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      for (int d = 0; d < LSC_DIGITS; d++) begin
        ram_q[d] <= '0;
      end
    end else if (byte_end && !first_q && !ovf_q) begin
      ram_q[addr_q] <= rx_q[LSC_SEGS-1:0];
    end
  end

  // Digit multiplexer: 16 sub-slots per digit, one per oscillator tick
  logic [$clog2(OSC_DIV)-1:0] div_q;
  logic [3:0] sub_q;
  logic [1:0] dig_q;
  logic       tick;

  assign tick = (div_q == ($clog2(OSC_DIV))'(OSC_DIV - 1));

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
      sub_q <= '0;
      dig_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
      if (tick) begin
        sub_q <= sub_q + 4'h1;
        if (sub_q == 4'hF) begin
          dig_q <= dig_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      segment_output_o <= '0;
      digit_output_o   <= '0;
      display_cfg_o    <= LSC_DISP_RST;
    end else begin
      display_cfg_o <= disp_q;
      if (disp_q.on) begin
        digit_output_o   <= LSC_DIGITS'(1) << dig_q;
        segment_output_o <= ({1'b0, sub_q} < lsc_width(disp_q.level)) ? ram_q[dig_q] : '0;
      end else begin
        digit_output_o   <= '0;
        segment_output_o <= '0;
      end
    end
  end

  a_ack_drive: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    byte_end && !stop && !start |=> bidir_serial_line_oe_o && !bidir_serial_line_o)
    else $error("acknowledge not driven after eighth falling edge");

  a_ack_release: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ack_q && rise && !stop && !start && !key_cmd |=> !bidir_serial_line_oe_o ##1 !bidir_serial_line_oe_o)
    else $error("acknowledge not released at ninth rising edge");

  a_ctrl_switch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    byte_end && is_ctrl |=> disp_q.on == $past(rx_q[LSC_ON_BIT]) ##2 display_cfg_o.on == disp_q.on)
    else $error("display switch not taken from control byte");

  a_ctrl_level: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    byte_end && is_ctrl |=> disp_q.level == $past(rx_q[2:0]))
    else $error("brightness not taken from control byte");

  a_addr_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    byte_end && is_addr |=> addr_q == $past(rx_q[1:0]) && !ovf_q)
    else $error("address command did not load pointer");

  a_fixed_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    byte_end && !first_q && fixed_q |=> $stable(addr_q))
    else $error("pointer moved in fixed address mode");

  a_auto_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    byte_end && !first_q && !fixed_q && !ovf_q && addr_q != LSC_ADDR_LAST
      |=> addr_q == $past(addr_q) + 2'h1)
    else $error("pointer did not advance in auto mode");

  a_past_last: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    byte_end && !first_q && ovf_q |=> $stable(ram_q[0]) && $stable(ram_q[1]) && $stable(ram_q[2]) && $stable(ram_q[3]))
    else $error("byte stored past last location");

  a_key_none: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ack_q && rise && key_cmd && !stop && !start && key_s2_q == '0 |=> st_q == LSC_TX && tx_q == LSC_KEY_NONE)
    else $error("idle key code wrong");

  a_blank_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !disp_q.on |=> digit_output_o == '0 && segment_output_o == '0)
    else $error("outputs not blanked with display off");

endmodule

`default_nettype wire

// ---- hdl/lsc_serial_ctrl_end.sv ----
// Empty companion source: all of the block's logic sits in lsc_serial_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

`default_nettype wire

// ---- verification/lsc_host_model.sv ----
// Host side model: drives the two-wire link from its own clock
`timescale 1ns/1ps
`default_nettype none
module lsc_host_model #(
  parameter int HALF = 10
) (
  input  wire logic lclk_i,
  input  wire logic line_i,
  output logic      serial_clk_o,
  output logic      line_low_o
);
  // Clock idles high and the line is released, so the pull-up holds it high
  initial begin
    serial_clk_o = 1'b1;
    line_low_o   = 1'b0;
  end
  // Each phase is HALF link ticks, 480 ns, so the 960 ns clock runs just above 1 MHz
  task automatic ph(input int n);
    repeat (n) @(posedge lclk_i);
    #1;
  endtask
  task automatic start_cond();  // Data falls while clock high
    serial_clk_o = 1'b1;
    ph(HALF);
    line_low_o = 1'b1;
    ph(HALF);
  endtask
  task automatic stop_cond();  // Clock dropped first, then data rises while clock high
    serial_clk_o = 1'b0;
    ph(HALF/2);
    line_low_o = 1'b1;
    ph(HALF/2);
    serial_clk_o = 1'b1;
    ph(HALF);
    line_low_o = 1'b0;
    ph(HALF);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 0; i < 8; i++) begin
      serial_clk_o = 1'b0;
      ph(HALF/2);
      line_low_o = ~b[i];  // LSB first, changed only with clock low
      ph(HALF/2);
      serial_clk_o = 1'b1;
      ph(HALF);
    end
    serial_clk_o = 1'b0;
    line_low_o = 1'b0;
    ph(HALF);
    ack = line_i;
    serial_clk_o = 1'b1;
    ph(HALF);
  endtask
  task automatic recv_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      serial_clk_o = 1'b0;
      ph(HALF);
      b[i] = line_i;
      serial_clk_o = 1'b1;
      ph(HALF);
    end
    // Ninth clock carries the host's own acknowledge
    serial_clk_o = 1'b0;
    ph(HALF/2);
    line_low_o = 1'b1;
    ph(HALF/2);
    serial_clk_o = 1'b1;
    ph(HALF);
  endtask
endmodule
`default_nettype wire

// ---- verification/led_driver_serial_command_control_tb_top.sv ----
// Self-checking bench for the serial LED command block
`timescale 1ns/1ps
`default_nettype none
module led_driver_serial_command_control_tb_top;
  import lsc_pkg::*;
  localparam int DIV = 4;
  typedef struct packed { logic [7:0] cmd; logic [3:0] cfg; int lit; } lsc_crow_t;
  typedef struct packed { logic [6:0] keys; logic [7:0] code; } lsc_krow_t;
  logic                  mclk, lclk, rst_n, sclk, host_low, line, dout, doe, ack;
  logic [LSC_KEYS-1:0]   key_in;
  logic [LSC_SEGS-1:0]   segment_output;
  logic [LSC_DIGITS-1:0] dig;
  lsc_disp_t             cfg;
  logic [7:0]            rd;
  int                    fail_count, checks, lit, rest, bad;
  logic [6:0] ram_exp [4] = '{7'h01, 7'h02, 7'h22, 7'h08};
  lsc_crow_t crow [9] = '{'{8'h88, 4'h8, 4}, '{8'h89, 4'h9, 8}, '{8'h8A, 4'hA, 16}, '{8'h8B, 4'hB, 40},
    '{8'h8C, 4'hC, 44}, '{8'h8D, 4'hD, 48}, '{8'h8E, 4'hE, 52}, '{8'h8F, 4'hF, 56}, '{8'h87, 4'h7, 0}};
  lsc_krow_t krow [9] = '{'{7'h01, 8'hEF}, '{7'h02, 8'h6F}, '{7'h04, 8'hAF}, '{7'h08, 8'h2F},
    '{7'h10, 8'hCF}, '{7'h20, 8'h4F}, '{7'h40, 8'h8F}, '{7'h00, 8'hFF}, '{7'h0C, 8'hAF}};
  // Open-drain line with pull-up: low if either side pulls it low
  assign line = ~(host_low | (doe & ~dout));
  lsc_serial_ctrl #(.OSC_DIV(DIV)) dut_u (.mclk_i(mclk), .rst_n_i(rst_n), .serial_clk_i(sclk),
    .bidir_serial_line_i(line), .bidir_serial_line_o(dout), .bidir_serial_line_oe_o(doe),
    .key_sense_inputs_i(key_in), .segment_output_o(segment_output), .digit_output_o(dig), .display_cfg_o(cfg));
  lsc_host_model #(.HALF(10)) host_u (.lclk_i(lclk), .line_i(line), .serial_clk_o(sclk), .line_low_o(host_low));
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;
  initial begin
    lclk = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_count(input int got, input int exp);
    checks++;
    if (got != exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b);
    host_u.send_byte(b, ack);
    check_val(ack, 1'b0);
  endtask
  task automatic frame1(input logic [7:0] b);
    host_u.start_cond();
    wr(b);
    host_u.stop_cond();
  endtask
  // One full multiplex round; lit counts digit 0 lit cycles, rest those of digits 1 to 3,
  // bad counts wrong segment patterns
  task automatic measure();
    int idx;
    lit = 0;
    rest = 0;
    bad = 0;
    repeat (16 * LSC_DIGITS * DIV) begin
      @(posedge mclk);
      #1;
      idx = (dig === 4'h2) ? 1 : (dig === 4'h4) ? 2 : (dig === 4'h8) ? 3 : 0;
      if (segment_output !== 7'h00 && segment_output === ram_exp[idx] && $onehot(dig)) begin
        if (idx == 0) lit++;
        else rest++;
      end
      if (segment_output !== 7'h00 && (cfg.on !== 1'b1 || !$onehot(dig) || segment_output !== ram_exp[idx])) bad++;
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Whole plan takes about 425 us
  initial begin
    #800_000;
    fail_count++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    key_in = 7'h00;
    fail_count = 0;
    checks = 0;
    repeat (6) @(posedge mclk);
    #1;
    check_val({cfg, doe, dig, segment_output}, 16'h0000);
    rst_n = 1'b1;
    repeat (8) @(posedge mclk);
    frame1(8'h40);
    host_u.start_cond();
    wr(8'hC0);
    foreach (ram_exp[i]) wr(8'h01 << i);
    wr(8'h10);
    host_u.stop_cond();
    frame1(8'h44);
    // Fixed mode: one byte per frame; rewriting a location replaces it and bit 7 is dropped
    host_u.start_cond();
    wr(8'hC2);
    wr(8'h11);
    host_u.stop_cond();
    host_u.start_cond();
    wr(8'hC2);
    wr(8'hA2);
    host_u.stop_cond();
    foreach (crow[i]) begin
      frame1(crow[i].cmd);
      repeat (8) @(posedge mclk);
      #1;
      check_val(cfg, crow[i].cfg);
      measure();
      check_count(lit, crow[i].lit);
      check_count(rest, 3 * crow[i].lit);
      check_count(bad, 0);
    end
    foreach (krow[i]) begin
      @(posedge mclk);
      #1;
      key_in = krow[i].keys;
      repeat (8) @(posedge mclk);
      host_u.start_cond();
      wr(LSC_KEY_READ);
      host_u.recv_byte(rd);
      host_u.stop_cond();
      check_val(rd, krow[i].code);
    end
    // Mid-run reset: outputs clear, and the display memory comes back empty
    @(posedge mclk);
    #1;
    rst_n = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    check_val({cfg, doe, dig, segment_output}, 16'h0000);
    rst_n = 1'b1;
    repeat (8) @(posedge mclk);
    frame1(8'h8F);
    repeat (8) @(posedge mclk);
    #1;
    check_val(cfg, 4'hF);
    measure();
    check_count(lit, 0);
    check_count(rest, 0);
    check_count(bad, 0);
    end_sim();
  end
endmodule
`default_nettype wire
